// File: rtl/lps_map.vh
// Constants for the low-power sleep state controller
// Assumes inclusion by the controller only; its synchroniser does not include it
`ifndef LPS_MAP_VH
`define LPS_MAP_VH

// One-hot state codes and their bit positions
`define LPS_ST_W          6
`define LPS_B_NORMAL      0
`define LPS_B_HALT        1
`define LPS_B_GRANT       2
`define LPS_B_SNOOP       3
`define LPS_B_SLEEP       4
`define LPS_B_DEEP        5
`define LPS_ST_NORMAL     6'h01
`define LPS_ST_HALT       6'h02
`define LPS_ST_GRANT      6'h04
`define LPS_ST_SNOOP      6'h08
`define LPS_ST_SLEEP      6'h10
`define LPS_ST_DEEP       6'h20
`define LPS_ST_RESET      6'h01

// Timing
`define LPS_CLK_MHZ       125
`define LPS_PLL_SETTLE_US 1000
`define LPS_SETTLE_CYC    (`LPS_PLL_SETTLE_US * `LPS_CLK_MHZ)
`define LPS_CNT_W         20

// Synchroniser depth
`define LPS_SYNC_STAGES   2

`endif

// File: rtl/lps_sync.v
// Two-stage level synchroniser for asynchronous inputs
// Assumes the inputs are levels held longer than one clock period
`timescale 1ns/10ps
`default_nettype none

module lps_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input  wire             i_clk,
   input  wire             i_rst,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;

   // First stage feeds only the second
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta   <= RESET_VAL;
         stable <= RESET_VAL;
      end else begin
         meta   <= i_async;
         stable <= meta;
      end
   end

   assign o_sync = stable;

endmodule // lps_sync

`default_nettype wire

// File: rtl/lps_ctrl.v
// Sleep and deep-sleep power-state controller on the bus clock
// Assumes chipset drives stop-clock, sleep, clock-stop notice and reset;
// snoop and halt inputs come from logic on the bus clock
`timescale 1ns/10ps
`default_nettype none
`include "lps_map.vh"

module lps_ctrl #(
   parameter SETTLE_CYC = `LPS_SETTLE_CYC,
   parameter IRQ_W      = 4
) (
   input  wire                  i_clk,
   input  wire                  i_rst,
   input  wire                  i_stop_clock_request_n,
   input  wire                  i_sleep_request_n,
   input  wire                  i_bus_clock_stopped,
   input  wire [IRQ_W-1:0]      i_irq,
   input  wire [IRQ_W-1:0]      i_irq_ack,
   input  wire                  i_halt_exec,
   input  wire                  i_wake_event,
   input  wire                  i_snoop_start,
   input  wire                  i_snoop_done,
   output reg  [`LPS_ST_W-1:0]  o_state,
   output reg                   o_core_clk_en,
   output reg                   o_l2_clk_en,
   output reg                   o_pll_run,
   output reg                   o_snoop_en,
   output reg                   o_settling,
   output reg  [IRQ_W-1:0]      o_irq_pending
);

   localparam integer          SETTLE_LAST_I = SETTLE_CYC - 1;
   localparam [`LPS_CNT_W-1:0] SETTLE_LAST   = SETTLE_LAST_I[`LPS_CNT_W-1:0];

   wire                  stop_req;
   wire                  sleep_req;
   wire                  clk_stopped;
   wire [IRQ_W-1:0]      irq_sync;
   wire [2:0]            req_sync;
   reg  [`LPS_ST_W-1:0]  next_state;
   reg                   from_halt;
   reg                   next_from_halt;
   reg                   snoop_to_halt;
   reg                   next_snoop_to_halt;
   reg  [`LPS_CNT_W-1:0] settle_cnt;
   reg  [`LPS_CNT_W-1:0] next_settle_cnt;
   reg                   settle_done;
   wire                  capture_ok;

   // Request pins synchronised, released pins read as inactive
   lps_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h3)
   ) u_req_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_bus_clock_stopped, i_sleep_request_n, i_stop_clock_request_n}),
      .o_sync  (req_sync)
   );

   lps_sync #(
      .WIDTH     (IRQ_W),
      .RESET_VAL ({IRQ_W{1'b0}})
   ) u_irq_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_irq),
      .o_sync  (irq_sync)
   );

   assign stop_req    = ~req_sync[0];
   assign sleep_req   = ~req_sync[1];
   assign clk_stopped = req_sync[2];

   // State transitions
   always @* begin
      next_state      = o_state;
      next_from_halt  = from_halt;
      next_snoop_to_halt = snoop_to_halt;
      next_settle_cnt = settle_cnt;
      settle_done     = (settle_cnt == SETTLE_LAST);
      case (o_state)
         `LPS_ST_NORMAL: begin
            // Sleep request has no effect here
            if (stop_req) begin
               next_state     = `LPS_ST_GRANT;
               next_from_halt = 1'b0;
            end else if (i_snoop_start) begin
               next_state = `LPS_ST_NORMAL;
            end else if (i_halt_exec) begin
               next_state = `LPS_ST_HALT;
            end
         end
         `LPS_ST_HALT: begin
            if (stop_req) begin
               next_state     = `LPS_ST_GRANT;
               next_from_halt = 1'b1;
            end else if (i_snoop_start) begin
               next_state         = `LPS_ST_SNOOP;
               next_snoop_to_halt = 1'b1;
            end else if (i_wake_event) begin
               next_state = `LPS_ST_NORMAL;
            end
         end
         `LPS_ST_GRANT: begin
            if (!stop_req) begin
               // Back to where the stop-clock request found the core
               if (from_halt) begin
                  next_state = `LPS_ST_HALT;
               end else begin
                  next_state = `LPS_ST_NORMAL;
               end
            end else if (sleep_req) begin
               next_state = `LPS_ST_SLEEP;
            end else if (i_snoop_start) begin
               next_state         = `LPS_ST_SNOOP;
               next_snoop_to_halt = 1'b0;
            end
         end
         `LPS_ST_SNOOP: begin
            // Grant keeps its own origin across a snoop
            if (i_snoop_done) begin
               if (snoop_to_halt) begin
                  next_state = `LPS_ST_HALT;
               end else begin
                  next_state = `LPS_ST_GRANT;
               end
               next_snoop_to_halt = 1'b0;
            end
         end
         `LPS_ST_SLEEP: begin
            // Snoops are not served here
            if (clk_stopped) begin
               next_state      = `LPS_ST_DEEP;
               next_settle_cnt = {`LPS_CNT_W{1'b0}};
            end else if (!sleep_req) begin
               next_state = `LPS_ST_GRANT;
            end
         end
         `LPS_ST_DEEP: begin
            // Clock running again: wait for PLL to settle
            if (clk_stopped) begin
               next_settle_cnt = {`LPS_CNT_W{1'b0}};
            end else if (settle_done) begin
               next_state      = `LPS_ST_SLEEP;
               next_settle_cnt = {`LPS_CNT_W{1'b0}};
            end else begin
               next_settle_cnt = settle_cnt + {{(`LPS_CNT_W-1){1'b0}}, 1'b1};
            end
         end
         default: begin
            next_state     = `LPS_ST_RESET;
            next_from_halt = 1'b0;
            next_snoop_to_halt = 1'b0;
         end
      endcase
   end

   // Asynchronous reset lands in normal from any state, sleep included
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_state    <= `LPS_ST_RESET;
         from_halt  <= 1'b0;
         snoop_to_halt <= 1'b0;
         settle_cnt <= {`LPS_CNT_W{1'b0}};
      end else begin
         o_state    <= next_state;
         from_halt  <= next_from_halt;
         snoop_to_halt <= next_snoop_to_halt;
         settle_cnt <= next_settle_cnt;
      end
   end

   // Interrupt capture is closed in both sleep states
   assign capture_ok = ~(o_state[`LPS_B_SLEEP] | o_state[`LPS_B_DEEP]);

   // Clock and snoop enables
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_core_clk_en <= 1'b1;
         o_l2_clk_en   <= 1'b1;
         o_pll_run     <= 1'b1;
         o_snoop_en    <= 1'b1;
         o_settling    <= 1'b0;
         o_irq_pending <= {IRQ_W{1'b0}};
      end else begin
         // Core clocks only in normal; context stays in registers
         o_core_clk_en <= next_state[`LPS_B_NORMAL];
         // Cache clock off only in deep sleep, back once in sleep
         o_l2_clk_en   <= ~next_state[`LPS_B_DEEP];
         // PLL kept in sleep, lost with the clock in deep sleep
         o_pll_run     <= ~next_state[`LPS_B_DEEP];
         // Snoopable in normal, idle, stop grant and snoop service
         o_snoop_en    <= ~(next_state[`LPS_B_SLEEP] | next_state[`LPS_B_DEEP]);
         o_settling    <= next_state[`LPS_B_DEEP] & ~clk_stopped;
         // New interrupt wins over an acknowledge in the same cycle
         o_irq_pending <= (o_irq_pending & ~i_irq_ack) | (irq_sync & {IRQ_W{capture_ok}});
      end
   end

endmodule // lps_ctrl

`default_nettype wire

// File: testbench/lps_ctrl_chk.sv
// Checker of the sleep state controller outputs
// Assumes binding to lps_ctrl ports
`timescale 1ns/10ps
`default_nettype none
module lps_ctrl_chk #(parameter IRQ_W = 4) (
   input wire logic             i_clk,
   input wire logic             i_rst,
   input wire logic             i_snoop_start,
   input wire logic             i_snoop_done,
   input wire logic [5:0]       o_state,
   input wire logic             o_core_clk_en,
   input wire logic             o_l2_clk_en,
   input wire logic             o_pll_run,
   input wire logic             o_snoop_en,
   input wire logic             o_settling,
   input wire logic [IRQ_W-1:0] o_irq_pending
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_grant_snoop;
      o_state == 6'h04 && i_snoop_start;
   endsequence
   sequence s_snoop_end;
      o_state == 6'h08 && i_snoop_done;
   endsequence
   a_state_one_hot: assert property ($onehot(o_state)) else $error("state");
   a_core_clk_map: assert property (o_core_clk_en == (o_state == 6'h01)) else $error("core");
   a_deep_clk_off: assert property ({o_l2_clk_en, o_pll_run} == {2{!o_state[5]}})
      else $error("l2 or pll");
   a_snoop_gate: assert property (o_snoop_en == !(o_state[4] || o_state[5]))
      else $error("snoop en");
   a_sleep_entry: assert property ($rose(o_state[4]) |-> $past(o_state[2]) || $past(o_state[5]))
      else $error("sleep entry");
   a_snoop_take: assert property (s_grant_snoop |=> o_state == 6'h08) else $error("snoop take");
   a_snoop_back: assert property (s_snoop_end |=> o_state[2] || o_state[1])
      else $error("snoop back");
   a_deep_wake: assert property ($fell(o_state[5]) |-> $past(o_settling) && o_state[4])
      else $error("deep exit");
   a_irq_frozen: assert property ((o_state[4] || o_state[5]) && $past(o_state[4] || o_state[5])
      |-> (o_irq_pending & ~$past(o_irq_pending)) == '0) else $error("irq set");
endmodule // lps_ctrl_chk
bind lps_ctrl lps_ctrl_chk #(.IRQ_W(IRQ_W)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_snoop_start(i_snoop_start), .i_snoop_done(i_snoop_done), .o_state(o_state),
   .o_core_clk_en(o_core_clk_en), .o_l2_clk_en(o_l2_clk_en), .o_pll_run(o_pll_run),
   .o_snoop_en(o_snoop_en), .o_settling(o_settling), .o_irq_pending(o_irq_pending));
`default_nettype wire

// File: testbench/lps_chipset.sv
// Chipset model: request pins, clock-stop notice and gated bus clock
// Assumes a free-running source clock and bench commands
`timescale 1ns/10ps
`default_nettype none
module lps_chipset (
   input  wire logic i_clk_src,
   input  wire logic i_rst,
   input  wire logic i_want_stop,
   input  wire logic i_want_sleep,
   input  wire logic i_want_deep,
   output var logic  o_stop_clock_request_n,
   output var logic  o_sleep_request_n,
   output var logic  o_bus_clock_stopped,
   output wire logic o_bus_clk
);
   logic       run;
   logic       run_q = 1'b1;
   logic [2:0] dly;
   assign o_bus_clk = i_clk_src & run_q;
   always @(negedge i_clk_src) run_q <= run;
   always @(posedge i_clk_src or posedge i_rst) begin
      if (i_rst) begin
         o_stop_clock_request_n <= 1'b1;
         o_sleep_request_n <= 1'b1;
         o_bus_clock_stopped <= 1'b0;
         run <= 1'b1;
         dly <= 3'h0;
      end else begin
         o_stop_clock_request_n <= !i_want_stop;
         o_sleep_request_n <= !i_want_sleep;
         if (i_want_deep) begin
            o_bus_clock_stopped <= 1'b1;
            dly <= dly + {2'h0, dly != 3'h7};
            if (dly == 3'h6) run <= 1'b0;
         end else begin
            run <= 1'b1;
            if (run_q) o_bus_clock_stopped <= 1'b0;
            dly <= 3'h0;
         end
      end
   end
endmodule // lps_chipset
`default_nettype wire

// File: testbench/lps_ctrl_test.sv
// Bench of the sleep state controller with a chipset model
// Assumes lps_ctrl, its checker and lps_chipset compiled first
`timescale 1ns/10ps
`default_nettype none
module lps_ctrl_test;
   typedef struct packed {logic stop; logic sleep; logic [5:0] st;} lps_row_t;
   localparam int SETTLE = 20;
   lps_row_t rows [5] = '{'{1'b0, 1'b1, 6'h01}, '{1'b1, 1'b0, 6'h04}, '{1'b1, 1'b1, 6'h10},
                          '{1'b1, 1'b0, 6'h04}, '{1'b0, 1'b0, 6'h01}};
   logic            clk = 1'b0, rst = 1'b1, stop = 1'b0, sleep = 1'b0, deep = 1'b0;
   logic [3:0]      ev = 4'h0, irq = 4'h0;
   wire logic       bclk, stop_n, sleep_n, clk_off, core, l2, pll, snp, stl;
   wire logic [5:0] state;
   wire logic [3:0] pend;
   int              miscompares = 0, samples_checked = 0, settle_cnt = 0;
   always #4 clk = ~clk;
   always @(posedge bclk) if (stl === 1'b1) settle_cnt++;
   lps_chipset ptn_u (.i_clk_src(clk), .i_rst(rst), .i_want_stop(stop), .i_want_sleep(sleep),
      .i_want_deep(deep), .o_stop_clock_request_n(stop_n), .o_sleep_request_n(sleep_n),
      .o_bus_clock_stopped(clk_off), .o_bus_clk(bclk));
   lps_ctrl #(.SETTLE_CYC(SETTLE), .IRQ_W(4)) dut_u (.i_clk(bclk), .i_rst(rst),
      .i_stop_clock_request_n(stop_n), .i_sleep_request_n(sleep_n), .i_bus_clock_stopped(clk_off),
      .i_irq(irq), .i_irq_ack(4'h0), .i_halt_exec(ev[0]), .i_wake_event(ev[1]),
      .i_snoop_start(ev[2]), .i_snoop_done(ev[3]), .o_state(state), .o_core_clk_en(core),
      .o_l2_clk_en(l2), .o_pll_run(pll), .o_snoop_en(snp), .o_settling(stl), .o_irq_pending(pend));
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input int b);
      @(posedge clk) ev[b] <= 1'b1;
      @(posedge clk) ev <= 4'h0;
      @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_st(input logic [5:0] s);
      int i;
      for (i = 0; i < 2000 && state !== s; i++) @(posedge clk);
      if (i == 2000) begin
         miscompares++;
         end_of_test();
      end
   endtask
   initial begin
      step(16);
      rst <= 1'b0;
      foreach (rows[k]) begin
         stop <= rows[k].stop;
         sleep <= rows[k].sleep;
         step(6);
         chk(state, rows[k].st);
         chk({core, snp}, {rows[k].st == 6'h01, rows[k].st != 6'h10});
      end
      $display("table done");
      pulse(0);
      sleep <= 1'b1;
      step(6);
      chk(state, 6'h02);
      sleep <= 1'b0;
      pulse(2);
      chk({l2, snp, state[3:0]}, 6'h38);
      pulse(3);
      chk(state, 6'h02);
      stop <= 1'b1;
      step(6);
      pulse(2);
      pulse(3);
      chk(state, 6'h04);
      stop <= 1'b0;
      step(6);
      chk(state, 6'h02);
      pulse(1);
      $display("idle done");
      irq <= 4'h5;
      stop <= 1'b1;
      step(6);
      sleep <= 1'b1;
      step(6);
      irq <= 4'hF;
      step(6);
      chk({pend, state[5:4]}, 6'h15);
      irq <= 4'h5;
      deep <= 1'b1;
      wait_st(6'h20);
      chk({l2, pll}, 6'h00);
      step(20);
      deep <= 1'b0;
      wait_st(6'h10);
      chk({settle_cnt == SETTLE - 1, l2}, 6'h03);
      sleep <= 1'b0;
      step(6);
      chk(state, 6'h04);
      sleep <= 1'b1;
      step(6);
      rst <= 1'b1;
      stop <= 1'b0;
      sleep <= 1'b0;
      step(2);
      chk(state, 6'h01);
      rst <= 1'b0;
      step(6);
      chk(state, 6'h01);
      $display("sleep done");
      end_of_test();
   end
endmodule // lps_ctrl_test
`default_nettype wire
